// File: hw/rct_controller.sv
// refresh counter test sequencer that drives a 64k x 4 dram
`timescale 1ns/1ps
module rct_controller (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [rct_pkg::ADDR_W-1:0] test_column,
    input wire logic [rct_pkg::DQ_W-1:0] dq_in,
    output rct_pkg::dram_pins_t pins,
    output logic busy,
    output logic done,
    output logic fail
);
    ////////////////////////////////////////////////////////////////
    rct_pkg::state_t state_reg, state_next;
    rct_pkg::phase_t phase_reg, phase_next;
    rct_pkg::dram_pins_t pins_reg, pins_next;
    logic [7:0] timer_reg, timer_next;
    logic [8:0] index_reg, index_next;
    logic [rct_pkg::ADDR_W-1:0] col_reg, col_next;
    logic pattern_reg, pattern_next;
    logic pass_reg, pass_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic fail_reg, fail_next;
    logic [rct_pkg::DQ_W-1:0] dq_meta_reg, dq_sync_reg;
    logic [rct_pkg::DQ_W-1:0] expect_val;
    logic last_row;

    // data pins come from the dram, so two flops before compare
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end else begin
            dq_meta_reg <= dq_in;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // test phase expects the old pattern; readback expects the newly written one
    assign expect_val = (phase_reg == rct_pkg::PH_TEST) ? {rct_pkg::DQ_W{pattern_reg}}
                                                        : {rct_pkg::DQ_W{~pattern_reg}};
    assign last_row = (index_reg == 9'(rct_pkg::ROW_COUNT - 1));

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        pins_next = pins_reg;
        timer_next = timer_reg;
        index_next = index_reg;
        col_next = col_reg;
        pattern_next = pattern_reg;
        pass_next = pass_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        fail_next = fail_reg;
        // one shared down-counter paces every step; a step acts only when it reaches zero
        if (timer_reg != 8'h00) begin
            timer_next = timer_reg - 8'h01;
        end else begin
            unique case (state_reg)
                rct_pkg::S_IDLE: begin
                    if (start) begin
                        col_next = test_column;
                        phase_next = rct_pkg::PH_INIT;
                        index_next = rct_pkg::INDEX_RST;
                        pattern_next = 1'b0;
                        pass_next = 1'b0;
                        fail_next = 1'b0;
                        busy_next = 1'b1;
                        state_next = rct_pkg::S_SETUP;
                    end
                end
                rct_pkg::S_SETUP: begin
                    // cbr cycles lower cas first; others put the row on the pins
                    if (phase_reg == rct_pkg::PH_INIT || phase_reg == rct_pkg::PH_TEST) begin
                        pins_next.cas_n = 1'b0;
                    end else begin
                        pins_next.addr = index_reg[7:0];
                    end
                    if (phase_reg == rct_pkg::PH_WRITE) begin
                        pins_next.we_n = 1'b0;
                        pins_next.dq_out = {rct_pkg::DQ_W{pattern_reg}};
                        pins_next.dq_oe = 1'b1;
                    end
                    timer_next = 8'(rct_pkg::SETUP_CYC - 1);
                    state_next = rct_pkg::S_RAS;
                end
                rct_pkg::S_RAS: begin
                    pins_next.ras_n = 1'b0;
                    if (phase_reg == rct_pkg::PH_INIT) begin
                        timer_next = 8'(rct_pkg::RAS_CYC - 1);
                        state_next = rct_pkg::S_PRE;
                    end else if (phase_reg == rct_pkg::PH_TEST) begin
                        timer_next = 8'(rct_pkg::CAS_CYC - 1);
                        state_next = rct_pkg::S_HOLD;
                    end else begin
                        timer_next = 8'(rct_pkg::SETUP_CYC - 1);
                        state_next = rct_pkg::S_CAS;
                    end
                end
                rct_pkg::S_CAS: begin
                    // normal cycle: column goes on the pins in the same step that cas falls
                    pins_next.addr = col_reg;
                    pins_next.cas_n = 1'b0;
                    pins_next.oe_n = (phase_reg == rct_pkg::PH_WRITE);
                    timer_next = 8'(rct_pkg::ACC_CYC - 1);
                    state_next = rct_pkg::S_WE;
                end
                rct_pkg::S_HOLD: begin
                    // cas rises under low ras; column set up before second fall
                    pins_next.cas_n = 1'b1;
                    pins_next.addr = col_reg;
                    timer_next = 8'(rct_pkg::CPT_CYC - 1);
                    state_next = rct_pkg::S_CPT;
                end
                rct_pkg::S_CPT: begin
                    // row is the device counter, no row is ever driven here
                    pins_next.cas_n = 1'b0;
                    pins_next.oe_n = 1'b0;
                    timer_next = 8'(rct_pkg::ACC_CYC - 1);
                    state_next = rct_pkg::S_CAS2;
                end
                rct_pkg::S_CAS2: begin
                    // read-modify-write: check old value, then write the complement
                    // oe rises with the write drive; a step apart would be kinder to the bus
                    if (dq_sync_reg != expect_val) begin
                        fail_next = 1'b1;
                    end
                    pins_next.oe_n = 1'b1;
                    pins_next.dq_out = {rct_pkg::DQ_W{~pattern_reg}};
                    pins_next.dq_oe = 1'b1;
                    pins_next.we_n = 1'b0;
                    timer_next = 8'(rct_pkg::CAS_CYC - 1);
                    state_next = rct_pkg::S_WE;
                end
                rct_pkg::S_WE: begin
                    if (phase_reg == rct_pkg::PH_READ && dq_sync_reg != expect_val) begin
                        fail_next = 1'b1;
                    end
                    timer_next = 8'(rct_pkg::CAS_CYC - 1);
                    state_next = rct_pkg::S_PRE;
                end
                rct_pkg::S_PRE: begin
                    pins_next.ras_n = 1'b1;
                    pins_next.cas_n = 1'b1;
                    pins_next.we_n = 1'b1;
                    pins_next.oe_n = 1'b1;
                    pins_next.dq_oe = 1'b0;
                    timer_next = 8'(rct_pkg::PRE_CYC - 1);
                    state_next = rct_pkg::S_SETUP;
                    index_next = index_reg + 9'h001;
                    if (phase_reg == rct_pkg::PH_INIT) begin
                        if (index_reg == 9'(rct_pkg::INIT_CBR_COUNT - 1)) begin
                            index_next = rct_pkg::INDEX_RST;
                            phase_next = rct_pkg::PH_WRITE;
                        end
                    end else if (last_row) begin
                        // 256 test cycles wrap the device counter back to the start row
                        index_next = rct_pkg::INDEX_RST;
                        unique case (phase_reg)
                            rct_pkg::PH_WRITE: phase_next = rct_pkg::PH_TEST;
                            rct_pkg::PH_TEST: phase_next = rct_pkg::PH_READ;
                            default: begin
                                if (pass_reg) begin
                                    state_next = rct_pkg::S_DONE;
                                end else begin
                                    pass_next = 1'b1;
                                    pattern_next = 1'b1;
                                    phase_next = rct_pkg::PH_WRITE;
                                end
                            end
                        endcase
                    end
                end
                rct_pkg::S_DONE: begin
                    // busy drops with done so a new start is taken on the next cycle
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    state_next = rct_pkg::S_IDLE;
                end
                default: state_next = rct_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rct_pkg::S_IDLE;
            phase_reg <= rct_pkg::PH_INIT;
            pins_reg <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                           addr: '0, dq_out: '0, dq_oe: 1'b0};
            timer_reg <= rct_pkg::TIMER_RST;
            index_reg <= rct_pkg::INDEX_RST;
            col_reg <= rct_pkg::COLUMN_RST;
            pattern_reg <= 1'b0;
            pass_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            pins_reg <= pins_next;
            timer_reg <= timer_next;
            index_reg <= index_next;
            col_reg <= col_next;
            pattern_reg <= pattern_next;
            pass_reg <= pass_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
        end
    end

    assign pins = pins_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign fail = fail_reg;
endmodule : rct_controller

// File: hw/rct_pkg.sv
// constants, types and state encoding for the refresh counter test controller
package rct_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned INIT_CBR_COUNT = 8;
    localparam int unsigned ROW_COUNT = 256;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DQ_W = 4;
    // phase lengths in ns; counts round up
    localparam int unsigned T_SETUP_NS = 30;
    localparam int unsigned T_RAS_NS = 500;
    localparam int unsigned T_CAS_NS = 70;
    localparam int unsigned T_PRE_NS = 110;
    localparam int unsigned T_CPT_NS = 70;
    localparam int unsigned T_ACC_NS = 210;
    localparam int unsigned SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CAS_CYC = (T_CAS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PRE_CYC = (T_PRE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CPT_CYC = (T_CPT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [8:0] INDEX_RST = 9'h000;
    localparam logic [ADDR_W-1:0] COLUMN_RST = 8'h00;

    typedef enum logic [1:0] {PH_INIT, PH_WRITE, PH_TEST, PH_READ} phase_t;
    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_RAS, S_CAS, S_HOLD, S_CPT, S_CAS2, S_WE, S_PRE, S_DONE
    } state_t;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq_out;
        logic dq_oe;
    } dram_pins_t;
endpackage : rct_pkg

// File: bench/rct_controller_asserts.sv
// port assertions for the refresh counter test controller
`timescale 1ns/1ps
module rct_controller_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [rct_pkg::ADDR_W-1:0] test_column,
    input wire logic [rct_pkg::DQ_W-1:0] dq_in,
    input rct_pkg::dram_pins_t pins,
    input wire logic busy,
    input wire logic done,
    input wire logic fail
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // strobe counts since the last start, for the end-of-test totals
    logic [10:0] ras_reg, ras_next, cbr_reg, cbr_next;
    logic [7:0] col_reg, col_next;
    logic ras_q_reg;
    logic ras_fall;
    always_comb begin
        ras_fall = ras_q_reg & ~pins.ras_n;
        ras_next = ras_reg + {10'h000, ras_fall};
        cbr_next = cbr_reg + {10'h000, ras_fall & ~pins.cas_n};
        col_next = col_reg;
        if (start && !busy) begin
            ras_next = 11'h000;
            cbr_next = 11'h000;
            col_next = test_column;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ras_reg <= 11'h000;
            cbr_reg <= 11'h000;
            col_reg <= 8'h00;
            ras_q_reg <= 1'b1;
        end else begin
            ras_reg <= ras_next;
            cbr_reg <= cbr_next;
            col_reg <= col_next;
            ras_q_reg <= pins.ras_n;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_init_cbr: assert property (ras_fall && ras_reg < 11'h008 |-> !pins.cas_n && $past(!pins.cas_n, 3))
        else $error("init cycle without cas low before ras");
    a_column_fixed: assert property ($fell(pins.cas_n) && !pins.ras_n |-> pins.addr == col_reg)
        else $error("column address differs from test column");
    a_done_counts: assert property (done |-> ras_reg == 11'h608 && cbr_reg == 11'h208)
        else $error("wrong number of ras cycles at done");
    a_done_pulse: assert property (done |=> !done && (!busy || $past(start)))
        else $error("done longer than one cycle");
    a_start_busy: assert property (start && !busy |-> ##[1:4] busy)
        else $error("start not followed by busy");
    a_fail_sticky: assert property (fail && busy |=> fail)
        else $error("fail dropped during test");
    a_pattern_drive: assert property (pins.dq_oe |-> pins.oe_n && (&pins.dq_out || ~|pins.dq_out))
        else $error("bad write pattern or drive clash");
    a_test_write: assert property ($fell(pins.we_n) && !pins.cas_n |-> pins.dq_oe)
        else $error("late write without data driven");
    c_done: cover property (done);
    c_fail: cover property ($rose(fail));
    c_cbr: cover property (ras_fall && !pins.cas_n);
endmodule : rct_controller_chk
bind rct_controller rct_controller_chk u_rct_controller_chk (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
    .test_column(test_column), .dq_in(dq_in), .pins(pins), .busy(busy), .done(done), .fail(fail));

// File: bench/dram_model.sv
// behavioural 64k x 4 dram with refresh counter and counter test access
`timescale 1ns/1ps
module dram_model (
    input wire logic ref_clk,
    input rct_pkg::dram_pins_t pins,
    input wire logic fault_en,
    output logic [3:0] dq,
    output int cbr_count
);
    logic [3:0] mem [0:65535];
    logic [7:0] ctr = 8'h00;
    logic [7:0] row, col;
    logic cbr = 1'b0;
    logic open_acc = 1'b0;
    logic [3:0] last_q = 4'h0;
    logic drive;
    initial cbr_count = 0;
    always @(negedge pins.ras_n) begin
        cbr = !pins.cas_n;
        row = cbr ? ctr : pins.addr;
        open_acc = 1'b0;
        if (cbr) begin
            ctr = ctr + 8'h01;
            cbr_count = cbr_count + 1;
        end
    end
    always @(negedge pins.cas_n) begin
        if (!pins.ras_n) begin
            col = pins.addr;
            open_acc = 1'b1;
            if (!pins.we_n) mem[{row, col}] = pins.dq_out;
        end
    end
    always @(negedge pins.we_n) if (open_acc && !pins.cas_n) mem[{row, col}] = pins.dq_out;
    always @(posedge pins.ras_n) open_acc = 1'b0;
    // released bus toggles so a stale value never passes for data
    assign drive = open_acc && !pins.cas_n && !pins.oe_n && pins.we_n;
    assign dq = drive ? (mem[{row, col}] ^ {3'h0, fault_en}) : ~last_q;
    always @(posedge ref_clk) last_q <= dq;
endmodule : dram_model

// File: bench/rct_controller_tb.sv
// self-checking bench for the refresh counter test controller
`timescale 1ns/1ps
module rct_controller_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic fault_en = 1'b0;
    logic [7:0] test_column = 8'h00;
    logic [3:0] dq_in;
    rct_pkg::dram_pins_t pins;
    logic busy, done, fail;
    int cbr_count, base, k;
    int n_fail = 0;
    int compares = 0;
    integer seed = 32'h904a53e5;
    rct_controller u_rct_controller (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .test_column(test_column),
        .dq_in(dq_in), .pins(pins), .busy(busy), .done(done), .fail(fail));
    dram_model u_dram_model (.ref_clk(ref_clk), .pins(pins), .fault_en(fault_en), .dq(dq_in), .cbr_count(cbr_count));
    always #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [3:0] pre_val(input int a);
        return a[3:0] ^ a[15:12];
    endfunction : pre_val
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic idle_chk;
        chk("idle outputs", {pins.ras_n, pins.cas_n, pins.we_n, pins.oe_n, pins.dq_oe, busy, done, fail, pins.addr},
            32'h0000f000);
    endtask : idle_chk
    // memory preload is a known function so untouched columns can be checked
    task automatic run(input logic flt, input logic [7:0] col);
        for (k = 0; k < 65536; k++) u_dram_model.mem[k] = pre_val(k);
        fault_en <= flt;
        test_column <= col;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        base = cbr_count;
    endtask : run
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1 idle_chk();
        @(posedge ref_clk);
        run(1'b1, 8'hff);
        for (k = 0; k < 60000 && fail !== 1'b1; k++) @(negedge ref_clk);
        chk("fail on bad read", fail, 1'b1);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1 idle_chk();
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        run(1'b0, 8'($random(seed)));
        // a start while busy must be ignored, its column too
        repeat (100) @(posedge ref_clk);
        test_column <= ~test_column;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        test_column <= ~test_column;
        for (k = 0; k < 110000 && done !== 1'b1; k++) @(negedge ref_clk);
        chk("done", done, 1'b1);
        chk("fail", fail, 1'b0);
        chk("cbr refresh count", cbr_count - base, rct_pkg::INIT_CBR_COUNT + 2 * rct_pkg::ROW_COUNT);
        for (k = 0; k < 65536; k++) begin
            chk("cell", u_dram_model.mem[k], (k[7:0] == test_column) ? 4'h0 : pre_val(k));
        end
        close_out();
    end
    // both runs together need about 117k cycles
    initial begin
        repeat (150000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end
endmodule : rct_controller_tb
